/* hdl/baud_gen.sv */
// Baud rate generator with low-frequency and oversampling modes
//
// Operation
// RULE1 - Oversample select low: one prescaler and modulator form bit clock.
// RULE2 - Low-frequency mode reaches a third of the source clock at most.
// RULE3 - Low-frequency mode votes three samples around mid bit.
// RULE4 - A bit with modulation one lasts one source clock longer.
// RULE5 - Per-bit pattern has eight positions, wraps, restarts per start.
// RULE6 - Second-stage setting picks an eight-bit pattern; start never longer.
// RULE7 - Oversample select high: sixteen-times clock, then bit clock stage.
// RULE8 - Oversampling mode reaches a sixteenth of source clock at most.
// RULE9 - Oversampling mode spaces the three votes one sixteenth bit apart.
// RULE10 - Oversampling with divisor zero or one bypasses the first stage.
// RULE11 - Sixteen-times period with modulation one is a clock longer.
// RULE12 - First-stage pattern has ones low from position one and at top.
// RULE13 - Oversampling bit clock is also lengthened per bit.
// RULE14 - Low-frequency bit lasts divisor plus its modulation.
// RULE15 - Oversampling bit lasts (16+m) times divisor plus first-stage ones.
// RULE16 - Software picks oversampling only with division factor of 16 up.
// RULE17 - Software sets low-frequency divisor and modulation from factor.
// RULE18 - Software sets oversampling divisor and first stage from factor.
// RULE19 - Software may tune second stage with first stage plus or minus one.
// RULE20 - Receive generator idles until start edge; stops if unconfirmed.
// RULE21 - Transmit generator starts on buffer write; stops without data.
// RULE22 - Divisor 16 bits, second-stage setting 3 bits, first-stage 4 bits.
// RULE23 - Counters reload at each bit boundary with that bit's modulation.
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`default_nettype none
module baud_gen
    import baud_gen_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Start and stop from the receive and transmit state machines
    input wire logic rx_start_edge_in,
    input wire logic rx_start_fail_in,
    input wire logic transmit_buffer_write_in,
    input wire logic tx_no_data_in,
    input wire logic rx_in,
    // Timing outputs
    output logic bit_timing_clock_out,
    output logic sixteen_times_bit_clock_out,
    output logic sample_out,
    output logic [2:0] bit_index_out,
    output logic running_out,
    output logic bit_value_out,
    output logic bit_valid_out
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic oversample_select;
        logic [15:0] prescale_divisor;
        logic [2:0] brs;
        logic [3:0] brf;
        logic ack;
        logic [31:0] rdat;
        logic run;
        logic [2:0] idx;
        logic [15:0] cnt;
        logic [4:0] sub;
        logic bit_tick;
        logic tick16;
        logic samp;
        logic samp_last;
        logic restart;
    } gen_state_t;

    gen_state_t st_q;
    gen_state_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // Per-bit and per-period lengths, derived from current position
    logic m_bit;
    logic m16;
    logic bypass;
    logic [15:0] lf_div;
    logic [16:0] lf_len;
    logic [16:0] lf_half;
    logic [16:0] os_len;
    logic [4:0] os_periods;
    logic [4:0] os_half;
    logic [16:0] cnt17;
    logic period_end;
    logic bit_end;
    logic wb_req;

    always_comb begin
        m_bit = brs_bit(st_q.brs, st_q.idx); // RULE6
        // Below the third-of-clock limit the divisor is held at three
        lf_div = (st_q.prescale_divisor < LF_MIN_DIVISOR) ?
                 LF_MIN_DIVISOR : st_q.prescale_divisor; // RULE2
        lf_len = {1'b0, lf_div} + {16'h0000, m_bit}; // RULE14 RULE4
        lf_half = {2'b00, lf_div[15:1]} + {16'h0000, m_bit}; // RULE3
        bypass = (st_q.prescale_divisor <= OS_BYPASS_MAX); // RULE10
        m16 = bypass ? 1'b0 : brf_bit(st_q.brf, st_q.sub); // RULE11 RULE12
        os_len = bypass ? 17'h00001 :
                 ({1'b0, st_q.prescale_divisor} + {16'h0000, m16});
        os_periods = OS_PERIODS + {4'h0, m_bit}; // RULE8 RULE13 RULE15
        os_half = OS_HALF + {4'h0, m_bit};
        cnt17 = {1'b0, st_q.cnt};
        if (st_q.oversample_select) begin
            period_end = (cnt17 == os_len - 17'h00001); // RULE7
            bit_end = period_end &&
                      (st_q.sub == os_periods - 5'h01); // RULE15
        end else begin
            period_end = (cnt17 == lf_len - 17'h00001); // RULE1
            bit_end = period_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register access and bit timing
    assign wb_req = wb_cyc_in && wb_stb_in;

    always_comb begin
        st_d = st_q;
        st_d.ack = wb_req && !st_q.ack;
        st_d.bit_tick = 1'b0;
        st_d.tick16 = 1'b0;
        st_d.samp = 1'b0;
        st_d.samp_last = 1'b0;
        st_d.restart = 1'b0;

        if (wb_req && !st_q.ack) begin
            st_d.rdat = 32'h00000000;
            case (wb_adr_in)
                CTRL_OFFSET: begin
                    st_d.rdat[CTRL_OS_BIT] = st_q.oversample_select;
                    if (wb_we_in && wb_sel_in[0]) begin
                        st_d.oversample_select = wb_dat_in[CTRL_OS_BIT];
                    end
                end
                DIVISOR_OFFSET: begin
                    st_d.rdat[15:0] = st_q.prescale_divisor; // RULE22
                    if (wb_we_in && wb_sel_in[0]) begin
                        st_d.prescale_divisor[7:0] = wb_dat_in[7:0];
                    end
                    if (wb_we_in && wb_sel_in[1]) begin
                        st_d.prescale_divisor[15:8] = wb_dat_in[15:8];
                    end
                end
                MOD_OFFSET: begin
                    st_d.rdat[MOD_BRS_LSB +: 3] = st_q.brs; // RULE22
                    st_d.rdat[MOD_BRF_LSB +: 4] = st_q.brf;
                    if (wb_we_in && wb_sel_in[0]) begin
                        st_d.brs = wb_dat_in[MOD_BRS_LSB +: 3];
                        st_d.brf = wb_dat_in[MOD_BRF_LSB +: 4];
                    end
                end
                STATUS_OFFSET: begin
                    st_d.rdat[STAT_RUN_BIT] = st_q.run;
                    st_d.rdat[STAT_OS_BIT] = st_q.oversample_select;
                    st_d.rdat[STAT_IDX_LSB +: 3] = st_q.idx;
                end
                default: begin
                    st_d.rdat = 32'h00000000;
                end
            endcase
        end

        if (rx_start_edge_in || transmit_buffer_write_in) begin
            // A start wins over a stop; a receive start, or any start while idle, restarts the pattern at bit 0
            if (!st_q.run || rx_start_edge_in) begin // RULE20 RULE21
                st_d.run = 1'b1;
                st_d.idx = 3'h0; // RULE5
                st_d.cnt = 16'h0000;
                st_d.sub = 5'h00;
                st_d.restart = 1'b1;
            end
        end else if (rx_start_fail_in || tx_no_data_in) begin
            st_d.run = 1'b0; // RULE20 RULE21
            st_d.cnt = 16'h0000;
            st_d.sub = 5'h00;
        end else if (st_q.run) begin
            if (st_q.oversample_select) begin
                // Votes at the starts of three neighbouring 16x periods
                if (st_q.cnt == 16'h0000 &&
                    st_q.sub >= os_half - 5'h01 &&
                    st_q.sub <= os_half + 5'h01) begin
                    st_d.samp = 1'b1; // RULE9
                    st_d.samp_last = (st_q.sub == os_half + 5'h01);
                end
                if (period_end) begin
                    st_d.cnt = 16'h0000;
                    st_d.tick16 = 1'b1;
                    st_d.sub = bit_end ? 5'h00 : st_q.sub + 5'h01; // RULE11
                end else begin
                    st_d.cnt = st_q.cnt + 16'h0001;
                end
            end else begin
                if (cnt17 + 17'h00001 >= lf_half &&
                    cnt17 <= lf_half + 17'h00001) begin
                    st_d.samp = 1'b1; // RULE3
                    st_d.samp_last = (cnt17 == lf_half + 17'h00001);
                end
                st_d.cnt = period_end ? 16'h0000 :
                           st_q.cnt + 16'h0001;
            end
            if (bit_end) begin
                st_d.bit_tick = 1'b1;
                st_d.idx = st_q.idx + 3'h1; // RULE5 RULE23
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '{
                oversample_select: RST_OS,
                prescale_divisor: RST_DIVISOR,
                brs: RST_BRS,
                brf: RST_BRF,
                ack: 1'b0,
                rdat: 32'h00000000,
                run: 1'b0,
                idx: 3'h0,
                cnt: 16'h0000,
                sub: 5'h00,
                bit_tick: 1'b0,
                tick16: 1'b0,
                samp: 1'b0,
                samp_last: 1'b0,
                restart: 1'b0
            };
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Majority vote on the samples, taken one cycle after the last strobe
    majority_voter voter (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .sample_in(st_q.samp),
        .last_sample_in(st_q.samp_last),
        .clear_in(st_q.restart),
        .rx_in(rx_in),
        .bit_value_out(bit_value_out),
        .bit_valid_out(bit_valid_out)
    );

    assign wb_ack_out = st_q.ack;
    assign wb_dat_out = st_q.rdat;
    assign bit_timing_clock_out = st_q.bit_tick;
    assign sixteen_times_bit_clock_out = st_q.tick16;
    assign sample_out = st_q.samp;
    assign bit_index_out = st_q.idx;
    assign running_out = st_q.run;

endmodule : baud_gen
`default_nettype wire

/* hdl/baud_gen_pkg.sv */
// Constants, register map and modulation lookups for the baud rate generator
`default_nettype none
package baud_gen_pkg;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] DIVISOR_OFFSET = 4'h4;
    localparam logic [3:0] MOD_OFFSET = 4'h8;
    localparam logic [3:0] STATUS_OFFSET = 4'hC;

    // Field positions
    localparam int CTRL_OS_BIT = 0;
    localparam int MOD_BRS_LSB = 0;
    localparam int MOD_BRF_LSB = 4;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_OS_BIT = 1;
    localparam int STAT_IDX_LSB = 4;

    // Reset values
    localparam logic RST_OS = 1'b0;
    localparam logic [15:0] RST_DIVISOR = 16'h0003;
    localparam logic [2:0] RST_BRS = 3'h0;
    localparam logic [3:0] RST_BRF = 4'h0;

    // Counts in source clocks and sixteen-times clock periods
    localparam logic [15:0] LF_MIN_DIVISOR = 16'h0003;
    localparam logic [4:0] OS_PERIODS = 5'h10;
    localparam logic [4:0] OS_HALF = 5'h08;
    localparam logic [15:0] OS_BYPASS_MAX = 16'h0001;

    // Per-bit lengthening pattern, bit i of entry = modulation of bit i
    localparam logic [7:0] BRS_PAT [8] = '{
        8'h00, 8'h02, 8'h22, 8'h2A, 8'hAA, 8'hAE, 8'hEE, 8'hFE
    };

    function automatic logic brs_bit(input logic [2:0] sel,
                                     input logic [2:0] pos);
        logic [7:0] pat;
        pat = BRS_PAT[sel];
        return pat[pos];
    endfunction : brs_bit

    // Ones at 1..ceil(k/2) and at the floor(k/2) top positions
    function automatic logic brf_bit(input logic [3:0] k,
                                     input logic [4:0] pos);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, k[3:1]} + {4'h0, k[0]};
        hi = 5'h10 - {2'h0, k[3:1]};
        if (pos == 5'h00 || pos > 5'h0F) begin
            return 1'b0;
        end
        return (pos <= lo) || (pos >= hi);
    endfunction : brf_bit

endpackage : baud_gen_pkg
`default_nettype wire

/* hdl/majority_voter.sv */
// Three-sample majority voter for one received bit
`default_nettype none
module majority_voter
    import baud_gen_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Sample strobes
    input wire logic sample_in,
    input wire logic last_sample_in,
    input wire logic clear_in,
    input wire logic rx_in,
    // Decision
    output logic bit_value_out,
    output logic bit_valid_out
);

    typedef struct packed {
        logic [1:0] samp;
        logic value;
        logic valid;
    } voter_state_t;

    voter_state_t st_q;
    voter_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.valid = 1'b0;
        if (clear_in) begin
            st_d.samp = 2'h0;
        end else if (sample_in && last_sample_in) begin
            // Two of three decide the bit
            st_d.value = (st_q.samp[0] & st_q.samp[1]) |
                         (rx_in & (st_q.samp[0] | st_q.samp[1]));
            st_d.valid = 1'b1;
        end else if (sample_in) begin
            st_d.samp = {st_q.samp[0], rx_in};
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '{samp: 2'h0, value: 1'b1, valid: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign bit_value_out = st_q.value;
    assign bit_valid_out = st_q.valid;

endmodule : majority_voter
`default_nettype wire

/* tb/baud_gen_chk.sv */
// Port checker of the baud rate generator
`default_nettype none
module baud_gen_chk (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Register bus
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    // Start and stop
    input wire logic rx_start_edge_in,
    input wire logic rx_start_fail_in,
    input wire logic transmit_buffer_write_in,
    input wire logic tx_no_data_in,
    // Timing outputs
    input wire logic bit_timing_clock_out,
    input wire logic sixteen_times_bit_clock_out,
    input wire logic sample_out,
    input wire logic [2:0] bit_index_out,
    input wire logic running_out,
    input wire logic bit_valid_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    property p_ack;
        s_req |=> wb_ack_out ##1 !wb_ack_out;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_unmapped;
        wb_ack_out && $past(!wb_we_in && wb_adr_in[1:0] != 2'h0)
            |-> wb_dat_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_restart;
        rx_start_edge_in |=> running_out && bit_index_out == 3'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_rx_abort;
        rx_start_fail_in && !rx_start_edge_in |=> !running_out;
    endproperty
    a_rx_abort: assert property (p_rx_abort) else $error("rx not off");
    property p_tx_stop;
        tx_no_data_in && !rx_start_edge_in && !transmit_buffer_write_in
            |=> !running_out;
    endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("tx not off");
    property p_tx_start;
        transmit_buffer_write_in && !rx_start_fail_in && !tx_no_data_in
            |=> running_out;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("tx not on");
    property p_quiet;
        !running_out && $past(!running_out)
            |-> !bit_timing_clock_out && !sixteen_times_bit_clock_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("clock while idle");
    property p_min_bit;
        bit_timing_clock_out |=> !bit_timing_clock_out [*2];
    endproperty
    a_min_bit: assert property (p_min_bit) else $error("bit too short");
    property p_vote;
        bit_valid_out |-> $past(sample_out);
    endproperty
    a_vote: assert property (p_vote) else $error("vote without sample");
endmodule : baud_gen_chk
bind baud_gen baud_gen_chk baud_gen_chk_i (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .rx_start_edge_in(rx_start_edge_in),
    .rx_start_fail_in(rx_start_fail_in), .tx_no_data_in(tx_no_data_in),
    .transmit_buffer_write_in(transmit_buffer_write_in),
    .bit_timing_clock_out(bit_timing_clock_out), .sample_out(sample_out),
    .sixteen_times_bit_clock_out(sixteen_times_bit_clock_out),
    .bit_index_out(bit_index_out), .running_out(running_out),
    .bit_valid_out(bit_valid_out));
`default_nettype wire

/* tb/serial_tx_model.sv */
// Remote serial transmitter driving the receive line
`default_nettype none
module serial_tx_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Control from the bench
    input wire logic send_in,
    input wire logic [7:0] byte_in,
    input wire logic bit_tick_in,
    // Serial line
    output logic rx_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] pos_q;
    logic [7:0] data_q;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pos_q <= 4'hF;
            data_q <= 8'h00;
        end else if (send_in) begin
            pos_q <= 4'h0;
            data_q <= byte_in;
        end else if (bit_tick_in && pos_q != 4'hF) begin
            pos_q <= pos_q + 4'h1;
        end
    end
    // Start bit low, data LSB first, then the model drives the line high
    always_comb begin
        rx_out = 1'b1;
        if (pos_q == 4'h0) begin
            rx_out = 1'b0;
        end else if (pos_q <= 4'h8) begin
            rx_out = data_q[pos_q[2:0] - 3'h1];
        end
    end
endmodule : serial_tx_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the baud rate generator
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import baud_gen_pkg::*;
    localparam logic [7:0] PAT [8] = '{8'h00, 8'h02, 8'h22, 8'h2A,
        8'hAA, 8'hAE, 8'hEE, 8'hFE};
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, seed = 32'h3B;
    logic wb_ack_out, rx_in, send = 1'b0, vote_on = 1'b0;
    logic rx_start_edge_in = 1'b0, rx_start_fail_in = 1'b0;
    logic transmit_buffer_write_in = 1'b0, tx_no_data_in = 1'b0;
    logic bit_timing_clock_out, sixteen_times_bit_clock_out, sample_out;
    logic running_out, bit_value_out, bit_valid_out;
    logic [2:0] bit_index_out;
    logic [7:0] bt = 8'h00;
    int mismatches = 0, total_checks = 0, vcnt = 0;
    always #12.5 mclk_in = ~mclk_in;
    baud_gen baud_gen_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .rx_in(rx_in),
        .rx_start_edge_in(rx_start_edge_in), .tx_no_data_in(tx_no_data_in),
        .rx_start_fail_in(rx_start_fail_in), .sample_out(sample_out),
        .transmit_buffer_write_in(transmit_buffer_write_in),
        .bit_timing_clock_out(bit_timing_clock_out),
        .sixteen_times_bit_clock_out(sixteen_times_bit_clock_out),
        .bit_index_out(bit_index_out), .running_out(running_out),
        .bit_value_out(bit_value_out), .bit_valid_out(bit_valid_out));
    serial_tx_model serial_tx_model_i (.mclk_in(mclk_in),
        .rst_n_in(rst_n_in), .send_in(send), .byte_in(bt),
        .bit_tick_in(bit_timing_clock_out), .rx_out(rx_in));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int bit_len(logic os, int dv, int s, int f, int i);
        int m;
        m = int'(PAT[s][i % 8]);
        if (!os) return ((dv < 3) ? 3 : dv) + m;
        if (dv <= 1) return 16 + m;
        return (16 + m) * dv + f;
    endfunction : bit_len
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
        total_checks++;
        if (seen !== ex) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic wb(logic we, logic [3:0] a, logic [3:0] sl,
                      logic [31:0] d, output logic [31:0] r);
        @(posedge mclk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_sel_in <= sl;
        wb_dat_in <= d;
        do begin
            @(posedge mclk_in);
        end while (wb_ack_out !== 1'b1);
        r = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask : wb
    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk_in) begin
        if (vote_on && bit_valid_out === 1'b1 && vcnt < 9) begin
            chk("vote", 32'(bit_value_out),
                32'(vcnt == 0 ? 1'b0 : bt[vcnt - 1]));
            vcnt++;
        end
    end
    initial begin
        repeat (60000) @(posedge mclk_in);
        mismatches++;
        give_verdict();
    end
    initial begin
        int dv, s, f, n;
        logic os, rxs;
        logic [31:0] r;
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        wb(1'b0, DIVISOR_OFFSET, 4'hF, 32'h0, r);
        chk("divisor", r, 32'h3);
        wb(1'b1, DIVISOR_OFFSET, 4'hF, 32'hFFFFFFFF, r);
        wb(1'b0, DIVISOR_OFFSET, 4'hF, 32'h0, r);
        chk("divisor", r, 32'hFFFF);
        wb(1'b1, MOD_OFFSET, 4'hF, 32'hFF, r);
        wb(1'b0, MOD_OFFSET, 4'hF, 32'h0, r);
        chk("mod", r, 32'hF7);
        wb(1'b0, 4'h2, 4'hF, 32'h0, r);
        chk("unmapped", r, 32'h0);
        for (int it = 0; it < 32; it++) begin
            os = it[0];
            rxs = it[1];
            // Oversampling only with a division factor of sixteen or more
            dv = os ? int'(rnd() % 4) : 3 + int'(rnd() % 16);
            dv = (it < 4) ? it / 2 : dv;
            s = os ? int'(rnd() % 8) : (it / 2) % 8;
            f = os ? it / 2 : 0;
            bt = 8'(rnd());
            wb(1'b1, CTRL_OFFSET, 4'h1, {31'h0, os}, r);
            wb(1'b1, DIVISOR_OFFSET, 4'h3, 32'(dv), r);
            wb(1'b1, MOD_OFFSET, 4'h1, 32'((f << 4) | s), r);
            @(posedge mclk_in);
            vote_on <= rxs && (os || dv >= 6);
            vcnt = 0;
            rx_start_edge_in <= rxs;
            send <= rxs;
            transmit_buffer_write_in <= !rxs;
            @(posedge mclk_in);
            rx_start_edge_in <= 1'b0;
            send <= 1'b0;
            transmit_buffer_write_in <= 1'b0;
            for (int b = 0; b < 9; b++) begin
                n = 0;
                r = 32'h0;
                do begin
                    @(posedge mclk_in);
                    #1;
                    n++;
                    r += 32'(sixteen_times_bit_clock_out);
                end while (bit_timing_clock_out !== 1'b1 && n < 2000);
                chk("bit_len", n, bit_len(os, dv, s, f, b));
                chk("index", 32'(bit_index_out), 32'((b + 1) % 8));
                if (!os) chk("x16_pulses", r, 32'h0);
                else chk("x16_pulses", r, 32'(16 + PAT[s][b % 8]));
            end
            @(posedge mclk_in);
            rx_start_fail_in <= rxs;
            tx_no_data_in <= !rxs;
            @(posedge mclk_in);
            rx_start_fail_in <= 1'b0;
            tx_no_data_in <= 1'b0;
            #1;
            chk("running", 32'(running_out), 32'h0);
        end
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
